// ===== design/ate_map.svh
// Register map, field positions, reset values and encodings of the
// threshold and calculation-error register slice.
// Assumes a 32-bit Avalon-MM slave; each register is one aligned word.
`ifndef ATE_MAP_SVH
`define ATE_MAP_SVH

`define ATE_ADDR_W            6
`define ATE_OFF_SETPT_LO      6'h00
`define ATE_OFF_SETPT_HI      6'h04
`define ATE_OFF_ERR_HI        6'h08
`define ATE_OFF_ERR_LO        6'h0c
`define ATE_OFF_LTH_HI        6'h10
`define ATE_OFF_LTH_LO        6'h14
`define ATE_OFF_UTH_HI        6'h18
`define ATE_OFF_UTH_LO        6'h1c
`define ATE_OFF_TRIG          6'h20
`define ATE_OFF_CTRL3         6'h24
`define ATE_OFF_STATUS        6'h28
`define ATE_OFF_IRQ_STAT      6'h2c
`define ATE_OFF_IRQ_MASK      6'h30

// Control register three: calc mode in bits 6:4, irq mode in bits 2:0
`define ATE_CTRL3_CALC_LSB    4
`define ATE_CTRL3_TMD_LSB     0
`define ATE_CTRL3_WMASK       8'h77
// Converter status: above-upper in bit 6, below-lower in bit 5
`define ATE_STAT_UTHR_BIT     6
`define ATE_STAT_LTHR_BIT     5
`define ATE_TRIG_WMASK        8'h1f
`define ATE_RST_BYTE          8'h00
// Interrupt status / mask: bit 0 threshold, bit 1 conversion done
`define ATE_IRQ_THR_BIT       0
`define ATE_IRQ_DONE_BIT      1
`define ATE_IRQ_W             2

`endif

// ===== design/ate_pkg.sv
// Types of the threshold and calculation-error register slice.
// Assumes ate_map.svh supplies the numeric constants.
package ate_pkg;

    // Calculation selected by the calc-mode field
    typedef enum logic [2:0] {
        ATE_CALC_FIRST_DERIV,
        ATE_CALC_SETPT_RES,
        ATE_CALC_SETPT_FLT,
        ATE_CALC_RSVD3,
        ATE_CALC_SETPT_AVG,
        ATE_CALC_RSVD5,
        ATE_CALC_ACT_DERIV,
        ATE_CALC_RSVD7
    } ate_calc_t;

    // Condition under which the threshold interrupt fires
    typedef enum logic [2:0] {
        ATE_TMD_NEVER,
        ATE_TMD_BELOW_LOW,
        ATE_TMD_ABOVE_HIGH_N,
        ATE_TMD_OUTSIDE,
        ATE_TMD_INSIDE,
        ATE_TMD_BELOW_LOW_N,
        ATE_TMD_ABOVE_HIGH,
        ATE_TMD_ALWAYS
    } ate_tmd_t;

    typedef enum {
        ATE_BUS_IDLE,
        ATE_BUS_ACK
    } ate_bus_t;

endpackage

// ===== design/ate_calc.sv
// Error calculation and threshold comparison, purely combinational.
// Assumes results and thresholds are signed 16-bit quantities.
`timescale 1ns/10ps
`default_nettype none

module ate_calc (
    // Operands
    input  wire logic [15:0]         result_in,
    input  wire logic [15:0]         prev_in,
    input  wire logic [15:0]         filter_in,
    input  wire logic [15:0]         setpoint_in,
    input  wire ate_pkg::ate_calc_t  calc_in,
    input  wire ate_pkg::ate_tmd_t   tmd_in,
    input  wire logic [15:0]         lower_in,
    input  wire logic [15:0]         upper_in,
    // Results
    output logic      [15:0]         error_out,
    output logic                     above_out,
    output logic                     below_out,
    output logic                     fire_out
);
    import ate_pkg::*;

    always_comb begin
        case (calc_in)
            ATE_CALC_FIRST_DERIV: error_out = result_in - prev_in;
            ATE_CALC_SETPT_RES:   error_out = result_in - setpoint_in;
            ATE_CALC_SETPT_FLT:   error_out = filter_in - setpoint_in;
            ATE_CALC_SETPT_AVG:   error_out = filter_in - setpoint_in;
            ATE_CALC_ACT_DERIV:   error_out = filter_in - prev_in;
            default:              error_out = result_in - setpoint_in;
        endcase
    end

    // Signed compare: the error is a difference and can go negative
    assign above_out = $signed(error_out) > $signed(upper_in);
    assign below_out = $signed(error_out) < $signed(lower_in);

    always_comb begin
        case (tmd_in)
            ATE_TMD_NEVER:        fire_out = 1'b0;
            ATE_TMD_BELOW_LOW:    fire_out = below_out;
            ATE_TMD_ABOVE_HIGH_N: fire_out = !above_out;
            ATE_TMD_OUTSIDE:      fire_out = below_out || above_out;
            ATE_TMD_INSIDE:       fire_out = !below_out && !above_out;
            ATE_TMD_BELOW_LOW_N:  fire_out = !below_out;
            ATE_TMD_ABOVE_HIGH:   fire_out = above_out;
            default:              fire_out = 1'b1;
        endcase
    end

endmodule

`default_nettype wire

// ===== design/ate_regs.sv
// Threshold / calculation-error register slice with Avalon-MM slave.
// Assumes the conversion engine pulses conv_done_in with its results.
//
// Register access over Avalon-MM and the placing of the registers were decided locally.
`include "ate_map.svh"
`timescale 1ns/10ps
`default_nettype none

module ate_regs (
    // Clock, reset, enable
    input  wire logic                   clk_in,
    input  wire logic                   rst_n_in,
    input  wire logic                   clk_en_in,
    // Avalon-MM slave
    input  wire logic [`ATE_ADDR_W-1:0] avs_address_in,
    input  wire logic                   avs_read_in,
    input  wire logic                   avs_write_in,
    input  wire logic [3:0]             avs_byteenable_in,
    input  wire logic [31:0]            avs_writedata_in,
    output logic      [31:0]            avs_readdata_out,
    output logic                        avs_waitrequest_out,
    output logic      [1:0]             avs_response_out,
    // Conversion engine
    input  wire logic                   conv_done_in,
    input  wire logic [15:0]            conv_result_in,
    input  wire logic [15:0]            conv_prev_in,
    input  wire logic [15:0]            conv_filter_in,
    // Block outputs
    output logic      [4:0]             trigger_source_select_out,
    output logic                        above_upper_flag_out,
    output logic                        below_lower_flag_out,
    output logic                        threshold_irq_out,
    output logic                        irq_out
);
    import ate_pkg::*;

    // ==============================================================
    // State
    typedef struct packed {
        logic [1:0]             rst_sync;
        ate_bus_t               bus;
        logic [31:0]            rdata;
        logic [1:0]             resp;
        logic [15:0]            setpoint;
        logic [15:0]            error;
        logic [15:0]            lower;
        logic [15:0]            upper;
        logic [4:0]             trig;
        logic [2:0]             calc;
        logic [2:0]             tmd;
        logic                   above;
        logic                   below;
        logic                   thr_irq;
        logic [`ATE_IRQ_W-1:0]  istat;
        logic [`ATE_IRQ_W-1:0]  imask;
        logic                   irq;
    } ate_state_t;

    ate_state_t state_q;
    ate_state_t state_d;
    logic       rst_n;

    logic [15:0]            err_calc;
    logic                   cmp_above;
    logic                   cmp_below;
    logic                   cmp_fire;
    logic                   wr_acc;
    logic                   req_new;
    logic [7:0]             wbyte;
    logic [`ATE_IRQ_W-1:0]  events;
    logic [7:0]             rbyte;
    logic                   hit;

    // ==============================================================
    // Reset release
    // The synchroniser runs off the free clock so release is not
    // delayed while the block is held by the clock enable.
    logic [1:0] rst_pipe_q;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rst_pipe_q <= 2'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_q[1];

    // ==============================================================
    // Calculation
    ate_calc u_calc (
        .result_in   (conv_result_in),
        .prev_in     (conv_prev_in),
        .filter_in   (conv_filter_in),
        .setpoint_in (state_q.setpoint),
        .calc_in     (ate_calc_t'(state_q.calc)),
        .tmd_in      (ate_tmd_t'(state_q.tmd)),
        .lower_in    (state_q.lower),
        .upper_in    (state_q.upper),
        .error_out   (err_calc),
        .above_out   (cmp_above),
        .below_out   (cmp_below),
        .fire_out    (cmp_fire)
    );

    // ==============================================================
    // Bus decode
    // One wait state per access: the request is answered the cycle
    // after it is seen, so waitrequest is low exactly one cycle.
    assign wr_acc = avs_write_in && state_q.bus == ATE_BUS_ACK;
    assign req_new = (avs_read_in || avs_write_in)
                     && state_q.bus == ATE_BUS_IDLE;
    assign wbyte  = avs_byteenable_in[0] ? avs_writedata_in[7:0]
                                         : 8'h00;

    always_comb begin
        hit = 1'b1;
        case (avs_address_in)
            `ATE_OFF_SETPT_LO: rbyte = state_q.setpoint[7:0];
            `ATE_OFF_SETPT_HI: rbyte = state_q.setpoint[15:8];
            `ATE_OFF_ERR_HI:   rbyte = state_q.error[15:8];
            `ATE_OFF_ERR_LO:   rbyte = state_q.error[7:0];
            `ATE_OFF_LTH_HI:   rbyte = state_q.lower[15:8];
            `ATE_OFF_LTH_LO:   rbyte = state_q.lower[7:0];
            `ATE_OFF_UTH_HI:   rbyte = state_q.upper[15:8];
            `ATE_OFF_UTH_LO:   rbyte = state_q.upper[7:0];
            `ATE_OFF_TRIG:     rbyte = {3'h0, state_q.trig};
            `ATE_OFF_CTRL3:
                rbyte = {1'b0, state_q.calc, 1'b0, state_q.tmd};
            `ATE_OFF_STATUS: begin
                rbyte = 8'h00;
                rbyte[`ATE_STAT_UTHR_BIT] = state_q.above;
                rbyte[`ATE_STAT_LTHR_BIT] = state_q.below;
            end
            `ATE_OFF_IRQ_STAT: rbyte = {6'h00, state_q.istat};
            `ATE_OFF_IRQ_MASK: rbyte = {6'h00, state_q.imask};
            default: begin
                rbyte = 8'h00;
                hit   = 1'b0;
            end
        endcase
    end

    // ==============================================================
    // Next state
    always_comb begin
        state_d          = state_q;
        state_d.rst_sync = 2'h3;
        events           = '0;

        case (state_q.bus)
            ATE_BUS_IDLE: begin
                if (avs_read_in || avs_write_in) begin
                    state_d.bus = ATE_BUS_ACK;
                end
            end
            ATE_BUS_ACK: begin
                state_d.bus = ATE_BUS_IDLE;
            end
            default: begin
                state_d.bus = ATE_BUS_IDLE;
            end
        endcase

        // Read data and response are latched as the request is seen, so
        // they already stand at the edge that samples waitrequest low.
        if (req_new && avs_read_in) begin
            state_d.rdata = {24'h0, rbyte};
        end
        if (req_new) begin
            state_d.resp = hit ? 2'b00 : 2'b10;
        end

        if (wr_acc && avs_byteenable_in[0]) begin
            case (avs_address_in)
                `ATE_OFF_SETPT_LO: state_d.setpoint[7:0] = wbyte;
                `ATE_OFF_SETPT_HI: state_d.setpoint[15:8] = wbyte;
                `ATE_OFF_LTH_HI:   state_d.lower[15:8] = wbyte;
                `ATE_OFF_LTH_LO:   state_d.lower[7:0] = wbyte;
                `ATE_OFF_UTH_HI:   state_d.upper[15:8] = wbyte;
                `ATE_OFF_UTH_LO:   state_d.upper[7:0] = wbyte;
                `ATE_OFF_TRIG:
                    state_d.trig = wbyte[4:0];
                `ATE_OFF_CTRL3: begin
                    state_d.calc = wbyte[`ATE_CTRL3_CALC_LSB +: 3];
                    state_d.tmd  = wbyte[`ATE_CTRL3_TMD_LSB +: 3];
                end
                `ATE_OFF_IRQ_MASK:
                    state_d.imask = wbyte[`ATE_IRQ_W-1:0];
                // Error bytes and status stay untouched by writes
                default: state_d.resp = state_d.resp;
            endcase
        end

        // Read of the interrupt status clears it in the cycle its data
        // is latched, so no event can slip between capture and clear;
        // events of that same cycle win below
        if (req_new && avs_read_in
            && avs_address_in == `ATE_OFF_IRQ_STAT) begin
            state_d.istat = '0;
        end

        if (conv_done_in) begin
            state_d.error   = err_calc;
            state_d.above   = cmp_above;
            state_d.below   = cmp_below;
            state_d.thr_irq = cmp_fire;
            events[`ATE_IRQ_THR_BIT]  = cmp_fire;
            events[`ATE_IRQ_DONE_BIT] = 1'b1;
        end else begin
            state_d.thr_irq = 1'b0;
        end
        state_d.istat = state_d.istat | events;
        state_d.irq   = |(state_d.istat & state_d.imask);
    end

    // ==============================================================
    // Registers
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= '0;
            state_q.bus <= ATE_BUS_IDLE;
        end else if (clk_en_in) begin
            state_q <= state_d;
        end
    end

    // ==============================================================
    // Outputs
    assign avs_readdata_out          = state_q.rdata;
    assign avs_response_out          = state_q.resp;
    assign trigger_source_select_out = state_q.trig;
    assign above_upper_flag_out      = state_q.above;
    assign below_lower_flag_out      = state_q.below;
    assign threshold_irq_out         = state_q.thr_irq;
    assign irq_out                   = state_q.irq;

    // Waitrequest from a flop: high except in the answer cycle
    logic wait_q;
    always_ff @(posedge clk_in or negedge rst_n) begin
        if (!rst_n) begin
            wait_q <= 1'b1;
        end else if (clk_en_in) begin
            wait_q <= !(state_d.bus == ATE_BUS_ACK);
        end
    end
    assign avs_waitrequest_out = wait_q;

endmodule

`default_nettype wire

// ===== sim/ate_regs_checker.sv
// Port-level assertions for the threshold register slice.
// Assumes one clock domain; bound to every ate_regs instance.
`include "ate_map.svh"
`timescale 1ns/10ps
`default_nettype none

module ate_regs_checker (
    // Clock, reset, enable
    input wire logic                   clk_in,
    input wire logic                   rst_n_in,
    input wire logic                   clk_en_in,
    // Bus
    input wire logic [`ATE_ADDR_W-1:0] avs_address_in,
    input wire logic                   avs_read_in,
    input wire logic                   avs_write_in,
    input wire logic [3:0]             avs_byteenable_in,
    input wire logic [31:0]            avs_writedata_in,
    input wire logic [31:0]            avs_readdata_out,
    input wire logic                   avs_waitrequest_out,
    // Block
    input wire logic                   conv_done_in,
    input wire logic [4:0]             trigger_source_select_out,
    input wire logic                   above_upper_flag_out,
    input wire logic                   below_lower_flag_out,
    input wire logic                   threshold_irq_out
);
    logic taken;
    logic trig_wr;
    logic trig_rd;

    assign taken = clk_en_in && !avs_waitrequest_out;
    assign trig_wr = taken && avs_write_in && avs_byteenable_in[0]
        && avs_address_in == `ATE_OFF_TRIG;
    assign trig_rd = taken && avs_read_in
        && avs_address_in == `ATE_OFF_TRIG;

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // ==========================
    // Bus handshake
    sequence s_req;
        clk_en_in && $rose(avs_read_in || avs_write_in);
    endsequence
    sequence s_answer;
        !avs_waitrequest_out;
    endsequence

    a_wait_one: assert property (s_req |=> s_answer)
        else $error("no answer one cycle after request");
    a_answer_short: assert property (taken |=> avs_waitrequest_out)
        else $error("waitrequest low for more than one cycle");

    // ==========================
    // Trigger select
    a_trig_write: assert property (trig_wr |=>
        trigger_source_select_out == $past(avs_writedata_in[4:0]))
        else $error("trigger select not stored");
    a_trig_hold: assert property (!trig_wr |=>
        $stable(trigger_source_select_out))
        else $error("trigger select changed without write");
    a_trig_read: assert property (trig_rd |->
        avs_readdata_out == {27'h0, trigger_source_select_out})
        else $error("trigger read wrong or top bits set");

    // ==========================
    // Conversion results
    a_flags_hold: assert property (!(clk_en_in && conv_done_in) |=>
        $stable({above_upper_flag_out, below_lower_flag_out}))
        else $error("flags moved without a conversion");
    a_thr_cause: assert property (threshold_irq_out && $past(clk_en_in)
        |-> $past(conv_done_in))
        else $error("threshold pulse without conversion");
    a_thr_single: assert property (clk_en_in && threshold_irq_out
        && !conv_done_in |=> !threshold_irq_out)
        else $error("threshold pulse longer than one cycle");
endmodule

bind ate_regs ate_regs_checker chk_u (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_byteenable_in(avs_byteenable_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .conv_done_in(conv_done_in),
    .trigger_source_select_out(trigger_source_select_out),
    .above_upper_flag_out(above_upper_flag_out),
    .below_lower_flag_out(below_lower_flag_out),
    .threshold_irq_out(threshold_irq_out)
);

`default_nettype wire

// ===== sim/ate_regs_test.sv
// Self-checking bench for the threshold register slice.
// Assumes ate_regs with its checker bound; one 250 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module ate_regs_test;
    logic        clk_in = 1'h0;
    logic        rst_n_in = 1'h0;
    logic        clk_en_in = 1'h1;
    logic [5:0]  adr = 6'h00;
    logic        rd_q = 1'h0;
    logic        wr_q = 1'h0;
    logic [3:0]  be_q = 4'h0;
    logic [31:0] wd_q = 32'h0;
    logic [31:0] rdata;
    logic        wait_rq;
    logic [1:0]  resp;
    logic        done = 1'h0;
    logic [15:0] res = 16'h0, prv = 16'h0, flt = 16'h0;
    logic [4:0]  trig;
    logic        above, below, thr, irq;
    int          fails = 0;
    int          compares = 0;
    logic [7:0]  mdl [14];

    ate_regs dut_u (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .clk_en_in(clk_en_in), .avs_address_in(adr), .avs_read_in(rd_q),
        .avs_write_in(wr_q), .avs_byteenable_in(be_q),
        .avs_writedata_in(wd_q), .avs_readdata_out(rdata),
        .avs_waitrequest_out(wait_rq), .avs_response_out(resp),
        .conv_done_in(done), .conv_result_in(res), .conv_prev_in(prv),
        .conv_filter_in(flt), .trigger_source_select_out(trig),
        .above_upper_flag_out(above), .below_lower_flag_out(below),
        .threshold_irq_out(thr), .irq_out(irq));

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    // ==========================
    // Model and bus tasks
    function automatic logic [15:0] calc(int m, logic [15:0] r, p, f, s);
        case (m)
            0: return r - p;
            2, 4: return f - s;
            6: return f - p;
            default: return r - s;
        endcase
    endfunction

    function automatic bit fire(int t, bit a, bit b);
        bit [7:0] v;
        v = {1'h1, a, !b, !a && !b, a || b, !a, b, 1'h0};
        return v[t];
    endfunction

    task automatic conclude();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(string n, logic [31:0] e, logic [31:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    // Holds the request until waitrequest is seen low at an edge
    task automatic acc(bit w, logic [5:0] a, logic [7:0] d, bit b,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_in);
        adr <= a;
        rd_q <= !w;
        wr_q <= w;
        be_q <= {3'($urandom), b};
        wd_q <= {24'($urandom), d};
        do begin
            @(posedge clk_in);
            n++;
        end while (wait_rq !== 1'h0 && n < 50);
        if (n >= 50) fails++;
        // Read data and response are taken at the accepting edge
        q = rdata;
        if (!w) chk("response", (a > 6'h30) ? 32'h2 : 32'h0, resp);
        rd_q <= 1'h0;
        wr_q <= 1'h0;
    endtask

    task automatic rd(logic [5:0] a, logic [7:0] e);
        logic [31:0] q;
        acc(0, a, 8'h00, 1, q);
        chk($sformatf("reg %h", a), {24'h0, e}, q);
    endtask

    task automatic wr(logic [5:0] a, logic [7:0] d);
        logic [31:0] q;
        acc(1, a, d, 1, q);
        case (a)
            6'h00, 6'h04, 6'h10, 6'h14, 6'h18, 6'h1c: mdl[a >> 2] = d;
            6'h20: mdl[8] = d & 8'h1f;
            6'h24: mdl[9] = d & 8'h77;
            6'h30: mdl[12] = d & 8'h03;
            default: ;
        endcase
    endtask

    initial begin
        #40000;
        fails++;
        conclude();
    end

    // ==========================
    // Scenarios
    initial begin
        logic [31:0] q;
        logic [15:0] e, lo, up, s;
        bit a, b, t;
        void'($urandom(81));
        foreach (mdl[i]) mdl[i] = 8'h00;
        repeat (5) @(posedge clk_in);
        rst_n_in <= 1'h1;
        repeat (3) @(posedge clk_in);
        for (int i = 0; i < 14; i++) rd(6'(i * 4), 8'h00);
        for (int i = 0; i < 14; i++) begin
            wr(6'(i * 4), 8'($urandom));
            rd(6'(i * 4), mdl[i]);
        end
        acc(1, 6'h00, ~mdl[0], 0, q);
        rd(6'h00, mdl[0]);
        // Every calc mode and every irq mode, mask varied
        for (int k = 0; k < 24; k++) begin
            lo = 16'($urandom_range(0, 200)) - 16'h0064;
            up = lo + 16'($urandom_range(0, 300));
            s = 16'($urandom_range(0, 200)) - 16'h0064;
            wr(6'h10, lo[15:8]);
            wr(6'h14, lo[7:0]);
            wr(6'h18, up[15:8]);
            wr(6'h1c, up[7:0]);
            wr(6'h04, s[15:8]);
            wr(6'h00, s[7:0]);
            wr(6'h24, {1'h0, 3'(k), 1'h0, 3'(k / 3)});
            wr(6'h30, 8'(k % 4));
            @(posedge clk_in);
            done <= 1'h1;
            res <= 16'($urandom_range(0, 255)) - 16'h0080;
            prv <= 16'($urandom_range(0, 255)) - 16'h0080;
            flt <= 16'($urandom_range(0, 255)) - 16'h0080;
            @(posedge clk_in);
            done <= 1'h0;
            e = calc(k % 8, res, prv, flt, s);
            a = $signed(e) > $signed(up);
            b = $signed(e) < $signed(lo);
            t = fire(k / 3, a, b);
            res <= 16'($urandom);
            prv <= 16'($urandom);
            @(negedge clk_in);
            chk("above", a, above);
            chk("below", b, below);
            chk("thr", t, thr);
            chk("irq", |({1'h1, t} & 2'(k)), irq);
            rd(6'h08, e[15:8]);
            rd(6'h0c, e[7:0]);
            wr(6'h0c, ~e[7:0]);
            rd(6'h0c, e[7:0]);
            rd(6'h28, {1'h0, a, b, 5'h00});
            rd(6'h2c, {6'h00, 1'h1, t});
            rd(6'h2c, 8'h00);
            @(negedge clk_in);
            chk("irq clear", 32'h0, irq);
        end
        conclude();
    end
endmodule

`default_nettype wire
